// ==== cpx_consts.svh ====
`ifndef CPX_CONSTS_SVH
`define CPX_CONSTS_SVH

// ----------------------------------------
// widths and sizes
// ----------------------------------------
`define CPX_DATA_W 8
`define CPX_ADDR_W 12
`define CPX_REG_COUNT 8
`define CPX_SCR_DEPTH 64
`define CPX_SCR_AW 6
`define CPX_STACK_DEPTH 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define CPX_PC_RESET 12'h000
`define CPX_ACC_RESET 8'h00

`endif

// ==== cpx_exec_props.sv ====
`timescale 1ns/100ps
module cpx_exec_props (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire logic busy,
	input wire logic done,
	input wire logic memRead,
	input wire logic memWrite,
	input wire logic dataOutEn,
	input wire logic [7:0] acc,
	input wire logic carryFlag,
	input wire logic decimalMode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ----------------
	// checks
	// ----------------
	take_busy_a: assert property (start && !busy |=> busy) else $error("busy not raised");
	done_time_a: assert property (start && !busy |=> ##[2:3] done) else $error("done late");
	done_pulse_a: assert property (done |=> !done) else $error("done too long");
	read_pulse_a: assert property (memRead |=> !memRead) else $error("read strobe long");
	no_both_a: assert property (!(memRead && memWrite)) else $error("both strobes");
	write_drive_a: assert property (memWrite |-> dataOutEn) else $error("data not driven");
	idle_hold_a: assert property (!busy && !start |=>
		$stable(acc) && $stable(carryFlag) && $stable(decimalMode))
		else $error("state moved while idle");
	dec_reset_a: assert property ($fell(srst) |-> !decimalMode) else $error("not binary after reset");
	rd_c: cover property (memRead);
	wr_c: cover property (memWrite);
	dec_c: cover property ($rose(decimalMode));
endmodule

bind cpx_exec_unit cpx_exec_props chk (.clk(clk), .srst(srst), .start(start), .busy(busy), .done(done),
	.memRead(memRead), .memWrite(memWrite), .dataOutEn(dataOutEn), .acc(acc), .carryFlag(carryFlag),
	.decimalMode(decimalMode));

// ==== cpx_exec_unit.sv ====
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "cpx_consts.svh"

// ----------------------------------------
// Contract
// - zero-test jump taken only when accumulator-nonzero flag is clear
// - immediate accumulator load copies byte, nonzero flag follows value
// - immediate register load writes byte into register low eight bits
// - indirect load addresses by pointer register zero, fills register low byte
// - external logic decodes address and returns byte on data bus
// - no-operation only advances program counter
// - output puts register on address bus, accumulator on data bus
// - plain left rotate of accumulator, carry untouched
// - right rotate binary by bit, decimal form works on any contents
// - scratch read uses low six register bits, sets nonzero flag
// - return pops stack top into program counter
// - left rotate through carry over nine bits
// - right rotate through carry over nine bits
// - binary clears, decimal sets decimal flag; reset gives binary
// - set-carry forces carry to one
// - indirect store addresses by pointer zero, drives register low byte
// - subtract carry and register byte, binary or two BCD digits
// - carry set on negative result, cleared otherwise
// - scratch subtract identical but subtrahend from scratch byte
// - scratch write stores accumulator at low six register bits
// - exchange swaps accumulator and register low byte
// - exclusive-or into accumulator, clears carry and half-carry, sets nonzero
// - taken jump replaces only low byte of program counter
// - jump page is that of the following instruction
// ----------------------------------------
module cpx_exec_unit (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire cpx_pkg::cpx_op_t opcode,
	input wire logic [2:0] regSel,
	input wire logic [`CPX_DATA_W-1:0] immByte,
	input wire logic [`CPX_ADDR_W-1:0] callTarget,
	input wire logic [`CPX_DATA_W-1:0] dataIn,
	output logic busy,
	output logic done,
	output logic [`CPX_ADDR_W-1:0] addrBus,
	output logic [`CPX_DATA_W-1:0] dataOut,
	output logic dataOutEn,
	output logic memRead,
	output logic memWrite,
	output logic [`CPX_ADDR_W-1:0] progCounter,
	output logic [`CPX_DATA_W-1:0] acc,
	output logic accNonzero,
	output logic carryFlag,
	output logic halfCarry,
	output logic decimalMode
);
	// ----------------------------------------
	// internal state
	// ----------------------------------------
	cpx_pkg::cpx_state_t state;
	cpx_pkg::cpx_op_t curOp;
	logic [2:0] curReg;
	logic [`CPX_DATA_W-1:0] curImm;
	logic [`CPX_ADDR_W-1:0] curTarget;
	logic [`CPX_ADDR_W-1:0] regFile [0:`CPX_REG_COUNT-1];
	logic [`CPX_ADDR_W-1:0] stack [0:`CPX_STACK_DEPTH-1];
	logic [1:0] stackPtr;
	logic [`CPX_ADDR_W-1:0] selReg;
	logic [`CPX_SCR_AW-1:0] scrAddr;
	logic scrWrite;
	logic [`CPX_DATA_W-1:0] scrData;
	logic [`CPX_DATA_W-1:0] subtrahend;
	logic [`CPX_DATA_W-1:0] next_acc;
	logic next_carry;
	logic next_half;
	logic writesAcc;
	logic [`CPX_ADDR_W-1:0] seqPc;
	logic execCycle;
	logic [8:0] binDiff;
	logic [4:0] loDiff;
	logic [4:0] hiDiff;
	logic loBorrow;
	logic [3:0] loDigit;
	logic [3:0] hiDigit;
	logic hiBorrowIn;

	assign selReg = regFile[curReg];
	assign execCycle = (state == cpx_pkg::ST_EXEC);
	assign seqPc = progCounter + 12'h001;
	assign scrAddr = selReg[`CPX_SCR_AW-1:0];
	assign scrWrite = execCycle && (curOp == cpx_pkg::OP_SCRATCH_WRITE);

	// ----------------------------------------
	// scratch memory
	// ----------------------------------------
	cpx_scratch_ram scratch (
		.clk(clk),
		.writeEn(scrWrite),
		.addr(scrAddr),
		.writeData(acc),
		.readData(scrData)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= cpx_pkg::ST_IDLE;
			curOp <= cpx_pkg::OP_NO_OPERATION;
			curReg <= 3'h0;
			curImm <= 8'h00;
			curTarget <= 12'h000;
		end else begin
			case (state)
				cpx_pkg::ST_IDLE: begin
					if (start) begin
						curOp <= opcode;
						curReg <= regSel;
						curImm <= immByte;
						curTarget <= callTarget;
						state <= cpx_pkg::ST_FETCH;
					end
				end
				cpx_pkg::ST_FETCH: state <= cpx_pkg::ST_EXEC;
				cpx_pkg::ST_EXEC: state <= cpx_pkg::ST_DONE;
				cpx_pkg::ST_DONE: state <= cpx_pkg::ST_IDLE;
				default: state <= cpx_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			busy <= (state == cpx_pkg::ST_IDLE) ? start : (state != cpx_pkg::ST_DONE);
			done <= execCycle;
		end
	end

	// ----------------------------------------
	// external bus
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			addrBus <= 12'h000;
			dataOut <= 8'h00;
			dataOutEn <= 1'b0;
			memRead <= 1'b0;
			memWrite <= 1'b0;
		end else begin
			memRead <= 1'b0;
			memWrite <= 1'b0;
			dataOutEn <= 1'b0;
			if (state == cpx_pkg::ST_IDLE && start) begin
				case (opcode)
					cpx_pkg::OP_LOAD_REGISTER_INDIRECT: begin
						addrBus <= regFile[0];
						memRead <= 1'b1;
					end
					cpx_pkg::OP_STORE_REGISTER_INDIRECT: begin
						addrBus <= regFile[0];
						dataOut <= regFile[regSel][7:0];
						dataOutEn <= 1'b1;
						memWrite <= 1'b1;
					end
					cpx_pkg::OP_OUTPUT_ACC: begin
						addrBus <= regFile[regSel];
						dataOut <= acc;
						dataOutEn <= 1'b1;
						memWrite <= 1'b1;
					end
					default: begin
						addrBus <= addrBus;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// subtract with borrow
	// ----------------------------------------
	always_comb begin
		subtrahend = (curOp == cpx_pkg::OP_SCRATCH_SUBTRACT_WITH_BORROW) ? scrData : selReg[7:0];
		binDiff = {1'b0, acc} - {1'b0, subtrahend} - {8'h00, carryFlag};
		loDiff = {1'b0, acc[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, carryFlag};
		loBorrow = loDiff[4] || (loDiff[3:0] > 4'h9);
		loDigit = loDiff[4] ? (loDiff[3:0] - 4'h6) : loDiff[3:0];
		hiBorrowIn = loDiff[4];
		hiDiff = {1'b0, acc[7:4]} - {1'b0, subtrahend[7:4]} - {4'h0, hiBorrowIn};
		hiDigit = hiDiff[4] ? (hiDiff[3:0] - 4'h6) : hiDiff[3:0];
	end

	// ----------------------------------------
	// accumulator datapath
	// ----------------------------------------
	always_comb begin
		next_acc = acc;
		next_carry = carryFlag;
		next_half = halfCarry;
		writesAcc = 1'b0;
		case (curOp)
			cpx_pkg::OP_LOAD_ACC_IMMEDIATE: begin
				next_acc = curImm;
				writesAcc = 1'b1;
			end
			cpx_pkg::OP_LOAD_REGISTER_INDIRECT: begin
				next_acc = acc;
			end
			cpx_pkg::OP_ROTATE_LEFT_PLAIN: begin
				next_acc = {acc[6:0], acc[7]};
				writesAcc = 1'b1;
			end
			cpx_pkg::OP_ROTATE_RIGHT_PLAIN: begin
				next_acc = decimalMode ? {acc[3:0], acc[7:4]} : {acc[0], acc[7:1]};
				writesAcc = 1'b1;
			end
			cpx_pkg::OP_SCRATCH_READ: begin
				next_acc = scrData;
				writesAcc = 1'b1;
			end
			cpx_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
				next_acc = {acc[6:0], carryFlag};
				next_carry = acc[7];
				writesAcc = 1'b1;
			end
			cpx_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
				next_acc = {carryFlag, acc[7:1]};
				next_carry = acc[0];
				writesAcc = 1'b1;
			end
			cpx_pkg::OP_SET_CARRY_FLAG: begin
				next_carry = 1'b1;
			end
			cpx_pkg::OP_SUBTRACT_WITH_BORROW, cpx_pkg::OP_SCRATCH_SUBTRACT_WITH_BORROW: begin
				if (decimalMode) begin
					next_acc = {hiDigit, loDigit};
					next_carry = hiDiff[4];
					next_half = loBorrow;
				end else begin
					next_acc = binDiff[7:0];
					next_carry = binDiff[8];
					next_half = loDiff[4];
				end
				writesAcc = 1'b1;
			end
			cpx_pkg::OP_EXCHANGE_ACC_REGISTER: begin
				next_acc = selReg[7:0];
				writesAcc = 1'b1;
			end
			cpx_pkg::OP_EXCLUSIVE_OR: begin
				next_acc = acc ^ selReg[7:0];
				next_carry = 1'b0;
				next_half = 1'b0;
				writesAcc = 1'b1;
			end
			default: begin
				next_acc = acc;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			acc <= `CPX_ACC_RESET;
			accNonzero <= 1'b0;
			carryFlag <= 1'b0;
			halfCarry <= 1'b0;
		end else if (execCycle) begin
			acc <= next_acc;
			carryFlag <= next_carry;
			halfCarry <= next_half;
			if (writesAcc) begin
				accNonzero <= (next_acc != 8'h00);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			decimalMode <= 1'b0;
		end else if (execCycle && curOp == cpx_pkg::OP_SET_BINARY_MODE) begin
			decimalMode <= 1'b0;
		end else if (execCycle && curOp == cpx_pkg::OP_SET_DECIMAL_MODE) begin
			decimalMode <= 1'b1;
		end
	end

	// ----------------------------------------
	// general registers, low byte writes only
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `CPX_REG_COUNT; gi = gi + 1) begin : gRegs
			always_ff @(posedge clk) begin
				if (srst) begin
					regFile[gi] <= 12'h000;
				end else if (execCycle && curReg == 3'(gi)) begin
					case (curOp)
						cpx_pkg::OP_LOAD_REGISTER_IMMEDIATE: regFile[gi][7:0] <= curImm;
						cpx_pkg::OP_LOAD_REGISTER_INDIRECT: regFile[gi][7:0] <= dataIn;
						cpx_pkg::OP_EXCHANGE_ACC_REGISTER: regFile[gi][7:0] <= acc;
						default: regFile[gi] <= regFile[gi];
					endcase
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// program counter and stack
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			progCounter <= `CPX_PC_RESET;
			stackPtr <= 2'h0;
		end else if (execCycle) begin
			case (curOp)
				cpx_pkg::OP_JUMP_IF_ACC_ZERO: begin
					if (!accNonzero) begin
						progCounter <= {seqPc[11:8], curImm};
					end else begin
						progCounter <= seqPc;
					end
				end
				cpx_pkg::OP_SUBROUTINE_RETURN: begin
					progCounter <= stack[stackPtr - 2'h1];
					stackPtr <= stackPtr - 2'h1;
				end
				cpx_pkg::OP_CALL: begin
					stack[stackPtr] <= seqPc;
					stackPtr <= stackPtr + 2'h1;
					progCounter <= curTarget;
				end
				default: progCounter <= seqPc;
			endcase
		end
	end
endmodule

// ==== cpx_mem_model.sv ====
`timescale 1ns/100ps
module cpx_mem_model (
	input wire logic clk,
	input wire logic memRead,
	input wire logic memWrite,
	input wire logic [11:0] addrBus,
	input wire logic [7:0] dataOut,
	output logic [7:0] dataIn
);
	// ----------------
	// external memory
	// ----------------
	logic [7:0] m [4096];
	initial begin
		dataIn = 8'h00;
		for (int k = 0; k < 4096; k++) m[k] = 8'(k) ^ 8'h5a;
	end
	always @(posedge clk) begin
		if (memRead) dataIn <= m[addrBus];
		else dataIn <= ~dataIn;
		if (memWrite) m[addrBus] <= dataOut;
	end
endmodule

// ==== cpx_pkg.sv ====
package cpx_pkg;
	typedef enum logic [4:0] {
		OP_NO_OPERATION,
		OP_JUMP_IF_ACC_ZERO,
		OP_LOAD_ACC_IMMEDIATE,
		OP_LOAD_REGISTER_IMMEDIATE,
		OP_LOAD_REGISTER_INDIRECT,
		OP_OUTPUT_ACC,
		OP_ROTATE_LEFT_PLAIN,
		OP_ROTATE_RIGHT_PLAIN,
		OP_SCRATCH_READ,
		OP_SUBROUTINE_RETURN,
		OP_ROTATE_LEFT_VIA_CARRY,
		OP_ROTATE_RIGHT_VIA_CARRY,
		OP_SET_BINARY_MODE,
		OP_SET_CARRY_FLAG,
		OP_SET_DECIMAL_MODE,
		OP_STORE_REGISTER_INDIRECT,
		OP_SUBTRACT_WITH_BORROW,
		OP_SCRATCH_SUBTRACT_WITH_BORROW,
		OP_SCRATCH_WRITE,
		OP_EXCHANGE_ACC_REGISTER,
		OP_EXCLUSIVE_OR,
		OP_CALL
	} cpx_op_t;

	typedef enum {
		ST_IDLE,
		ST_FETCH,
		ST_EXEC,
		ST_DONE
	} cpx_state_t;
endpackage

// ==== cpx_scratch_ram.sv ====
`timescale 1ns/100ps
`include "cpx_consts.svh"

module cpx_scratch_ram (
	input wire logic clk,
	input wire logic writeEn,
	input wire logic [`CPX_SCR_AW-1:0] addr,
	input wire logic [`CPX_DATA_W-1:0] writeData,
	output logic [`CPX_DATA_W-1:0] readData
);
	logic [`CPX_DATA_W-1:0] mem [0:`CPX_SCR_DEPTH-1];

	// ----------------------------------------
	// write port, registered read
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (writeEn) begin
			mem[addr] <= writeData;
		end
	end

	always_ff @(posedge clk) begin
		readData <= mem[addr];
	end
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic start = 1'b0;
	cpx_pkg::cpx_op_t opcode = cpx_pkg::OP_NO_OPERATION;
	logic [2:0] regSel = 3'h0;
	logic [7:0] immByte = 8'h00;
	logic [11:0] callTarget = 12'h000;
	logic [7:0] dataIn, dataOut, acc;
	logic [11:0] addrBus, progCounter;
	logic busy, done, dataOutEn, memRead, memWrite, accNonzero, carryFlag, halfCarry, decimalMode;
	int fail_count = 0;
	int comparisons = 0;
	int seed = 32'h32dbf45b;
	int a = 0, cy = 0, dm = 0, nz = 0, rp = 0;
	int rg [8];
	int sc [64];
	cpx_pkg::cpx_op_t o;
	always #5 clk = ~clk;
	cpx_exec_unit uut (.clk(clk), .srst(srst), .start(start), .opcode(opcode), .regSel(regSel), .immByte(immByte),
		.callTarget(callTarget), .dataIn(dataIn), .busy(busy), .done(done), .addrBus(addrBus), .dataOut(dataOut),
		.dataOutEn(dataOutEn), .memRead(memRead), .memWrite(memWrite), .progCounter(progCounter), .acc(acc),
		.accNonzero(accNonzero), .carryFlag(carryFlag), .halfCarry(halfCarry), .decimalMode(decimalMode));
	cpx_mem_model mem (.clk(clk), .memRead(memRead), .memWrite(memWrite), .addrBus(addrBus), .dataOut(dataOut),
		.dataIn(dataIn));
	// ----------------
	// helpers
	// ----------------
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic ex(input cpx_pkg::cpx_op_t op, input int r, input int i);
		logic [11:0] p1;
		int b, lo, hi, bl, n;
		p1 = progCounter + 12'h001;
		if (op == cpx_pkg::OP_JUMP_IF_ACC_ZERO) i = progCounter[7:0] + 8'h80;
		b = rg[r] & 255;
		if (op == cpx_pkg::OP_SCRATCH_SUBTRACT_WITH_BORROW || op == cpx_pkg::OP_SCRATCH_READ) b = sc[rg[r] % 64];
		opcode <= op;
		regSel <= 3'(r);
		immByte <= 8'(i);
		callTarget <= 12'(i * 13);
		start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 20);
		if (n >= 20) fail_count++;
		case (op)
			cpx_pkg::OP_JUMP_IF_ACC_ZERO: if (!nz) chk("jump", progCounter, {p1[11:8], 8'(i)});
				else chk("seq", progCounter, p1);
			cpx_pkg::OP_LOAD_ACC_IMMEDIATE: a = i;
			cpx_pkg::OP_LOAD_REGISTER_IMMEDIATE: rg[r] = (rg[r] & 'hf00) | i;
			cpx_pkg::OP_LOAD_REGISTER_INDIRECT: rg[r] = (rg[r] & 'hf00) | mem.m[rg[0]];
			cpx_pkg::OP_OUTPUT_ACC: begin
				chk("addr", addrBus, 12'(rg[r]));
				chk("outmem", 12'(mem.m[rg[r]]), 12'(a));
			end
			cpx_pkg::OP_ROTATE_LEFT_PLAIN: a = ((a << 1) | (a >> 7)) & 255;
			cpx_pkg::OP_ROTATE_RIGHT_PLAIN: a = dm ? ((a << 4) | (a >> 4)) & 255 : ((a >> 1) | (a << 7)) & 255;
			cpx_pkg::OP_SCRATCH_READ: a = b;
			cpx_pkg::OP_SUBROUTINE_RETURN: chk("ret", progCounter, 12'(rp));
			cpx_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin b = cy; cy = a >> 7; a = ((a << 1) | b) & 255; end
			cpx_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin b = cy; cy = a & 1; a = (a >> 1) | (b << 7); end
			cpx_pkg::OP_SET_BINARY_MODE: dm = 0;
			cpx_pkg::OP_SET_CARRY_FLAG: cy = 1;
			cpx_pkg::OP_SET_DECIMAL_MODE: dm = 1;
			cpx_pkg::OP_STORE_REGISTER_INDIRECT: chk("store", 12'(mem.m[rg[0]]), 12'(rg[r]));
			cpx_pkg::OP_SUBTRACT_WITH_BORROW, cpx_pkg::OP_SCRATCH_SUBTRACT_WITH_BORROW: begin
				lo = a % 16 - b % 16 - cy;
				if (dm) begin
					bl = lo < 0;
					if (bl) lo -= 6;
					hi = a / 16 - b / 16 - bl;
					cy = hi < 0;
					if (cy) hi -= 6;
					a = ((hi & 15) << 4) | (lo & 15);
				end else begin
					chk("half", 12'(halfCarry), 12'(lo < 0));
					lo = a - b - cy;
					cy = lo < 0;
					a = lo & 255;
				end
			end
			cpx_pkg::OP_SCRATCH_WRITE: sc[rg[r] % 64] = a;
			cpx_pkg::OP_EXCHANGE_ACC_REGISTER: begin b = a; a = rg[r] & 255; rg[r] = (rg[r] & 'hf00) | b; end
			cpx_pkg::OP_EXCLUSIVE_OR: begin
				a = a ^ b;
				cy = 0;
				chk("half", 12'(halfCarry), 12'h000);
			end
			cpx_pkg::OP_NO_OPERATION: chk("nop", progCounter, p1);
			cpx_pkg::OP_CALL: begin rp = p1; chk("call", progCounter, 12'(i * 13)); end
			default: ;
		endcase
		chk("acc", 12'(acc), 12'(a));
		chk("carry", 12'(carryFlag), 12'(cy));
		chk("dec", 12'(decimalMode), 12'(dm));
		if (op inside {cpx_pkg::OP_LOAD_ACC_IMMEDIATE, cpx_pkg::OP_ROTATE_LEFT_PLAIN, cpx_pkg::OP_ROTATE_RIGHT_PLAIN,
			cpx_pkg::OP_SCRATCH_READ, cpx_pkg::OP_ROTATE_LEFT_VIA_CARRY, cpx_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
			cpx_pkg::OP_SUBTRACT_WITH_BORROW, cpx_pkg::OP_SCRATCH_SUBTRACT_WITH_BORROW,
			cpx_pkg::OP_EXCHANGE_ACC_REGISTER, cpx_pkg::OP_EXCLUSIVE_OR}) nz = a != 0;
		chk("nz", 12'(accNonzero), 12'(nz));
		@(posedge clk);
	endtask
	// ----------------
	// sequence
	// ----------------
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end
	initial begin
		foreach (rg[k]) rg[k] = 0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk("acc0", 12'(acc), 12'h000);
		chk("dec0", 12'(decimalMode), 12'h000);
		@(posedge clk);
		for (int k = 0; k < 64; k++) begin
			ex(cpx_pkg::OP_LOAD_ACC_IMMEDIATE, 0, $random(seed) & 255);
			ex(cpx_pkg::OP_LOAD_REGISTER_IMMEDIATE, 0, k + 64 * (k % 4));
			ex(cpx_pkg::OP_SCRATCH_WRITE, 0, 0);
		end
		ex(cpx_pkg::OP_LOAD_ACC_IMMEDIATE, 0, 0);
		ex(cpx_pkg::OP_JUMP_IF_ACC_ZERO, 0, 0);
		ex(cpx_pkg::OP_LOAD_ACC_IMMEDIATE, 0, 5);
		ex(cpx_pkg::OP_JUMP_IF_ACC_ZERO, 0, 0);
		ex(cpx_pkg::OP_CALL, 0, 7);
		ex(cpx_pkg::OP_NO_OPERATION, 0, 0);
		ex(cpx_pkg::OP_SUBROUTINE_RETURN, 0, 0);
		for (int k = 0; k < 400; k++) begin
			o = cpx_pkg::cpx_op_t'(5'($unsigned($random(seed)) % 21));
			if (o == cpx_pkg::OP_SUBROUTINE_RETURN) o = cpx_pkg::OP_NO_OPERATION;
			ex(o, $random(seed) & 7, $random(seed) & 255);
		end
		ex(cpx_pkg::OP_SET_DECIMAL_MODE, 0, 0);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk("dec1", 12'(decimalMode), 12'h000);
		chk("acc1", 12'(acc), 12'h000);
		wrap_up();
	end
endmodule
